// *** include/sdc_pkg.sv ***
// Shared constants and types for the component-mode serdes clocking block
// What this block does
// (RQ1) Capture serial data on both fast-clock phases
// (RQ2) Deliver words at fast rate over width/2
// (RQ3) Fabric feeds one divided clock to FIFO read
// (RQ4) Without FIFO, words follow internal divided strobe
// (RQ5) Serializer samples parallel words on divided strobe
// (RQ6) Serializer shifts bit pairs on fast clock
// (RQ7) Width two needs no divided clock
// (RQ8) Tristate control is a combinational feed-through
// (RQ9) Delay line control clock equals divided clock
// (RQ10) All nibble delays share one reference rate setting
// (RQ11) Ready only when all nibble delays calibrated
// (RQ12) Release application 64 cycles after ready; code raises app_release 65 cycles after calibration_done_flag rises
package sdc_pkg;
    // Parallel word width and double-data-rate bits per fast cycle
    localparam int unsigned SDC_DATA_WIDTH = 8;
    localparam int unsigned SDC_DDR_BITS = 2;
    // Delay lines per nibble: native and mixed component ones
    localparam int unsigned SDC_NATIVE_LINES = 4;
    localparam int unsigned SDC_COMPONENT_LINES = 2;
    // Cycles of settled readiness before the application is released
    localparam int unsigned SDC_RELEASE_CYCLES = 64;
    localparam int unsigned SDC_RELEASE_CNT_W = 7;
    // Reset values of the sticky, valid, ready and release flags
    localparam logic SDC_FLAG_RESET = 1'b0;

    // Release sequencer states, one-hot
    typedef enum logic [2:0] {
        SDC_CAL_WAIT = 3'b001,
        SDC_CAL_HOLD = 3'b010,
        SDC_CAL_RUN = 3'b100
    } sdc_release_state_t;
endpackage : sdc_pkg

// *** hdl/sdc_word_buffer.sv ***
// Two-entry word buffer with registered outputs between deserializer and fabric
`timescale 1ns/10ps
`default_nettype none
module sdc_word_buffer #(
    parameter int unsigned WIDTH = sdc_pkg::SDC_DATA_WIDTH
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    import sdc_pkg::*;

    // A word needs at least one bit
    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be at least one");
    end

    logic spare_valid;
    logic [WIDTH-1:0] spare_data;
    wire out_free = out_ready || !out_valid;
    wire in_take = in_valid && in_ready;

    // The spare entry only fills while the output stage is stalled
    assign in_ready = !spare_valid;

    // Output stage: spare first, so words leave in arrival order
    always_ff @(posedge core_clk) begin
        if (reset) begin
            out_valid <= SDC_FLAG_RESET;
            out_data <= '0;
            spare_valid <= SDC_FLAG_RESET;
            spare_data <= '0;
        end else if (out_free) begin
            if (spare_valid) begin
                out_data <= spare_data;
                out_valid <= 1'b1;
                spare_valid <= 1'b0;
            end else begin
                out_data <= in_data;
                out_valid <= in_valid;
            end
        end else if (in_take) begin
            spare_data <= in_data;
            spare_valid <= 1'b1;
        end
    end

    a_hold_stall: assert property (@(posedge core_clk) disable iff (reset)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("buffer output changed while stalled");
    a_full_refuse: assert property (@(posedge core_clk) disable iff (reset)
        spare_valid && !out_ready |=> !in_ready)
        else $error("full buffer accepted a word");
    a_pass_through: assert property (@(posedge core_clk) disable iff (reset)
        in_take && !out_valid |=> out_valid && out_data == $past(in_data))
        else $error("word did not reach empty output");
    c_buffer_fills: cover property (@(posedge core_clk) disable iff (reset) spare_valid);
endmodule : sdc_word_buffer
`default_nettype wire

// *** hdl/sdc_serdes.sv ***
// Component-mode deserializer, serializer, word divider and calibration release
`timescale 1ns/10ps
`default_nettype none
module sdc_serdes #(
    parameter int unsigned DATA_WIDTH = sdc_pkg::SDC_DATA_WIDTH,
    parameter int unsigned NATIVE_LINES = sdc_pkg::SDC_NATIVE_LINES,
    parameter int unsigned COMPONENT_LINES = sdc_pkg::SDC_COMPONENT_LINES
) (
    input wire logic core_clk,
    input wire logic reset,
    // Serial line, one bit per fast-clock phase
    input wire logic ser_in_rise,
    input wire logic ser_in_fall,
    output logic ser_out_rise,
    output logic ser_out_fall,
    input wire logic tx_block_tri,
    output logic pad_oe_n,
    // Divided word strobe
    output logic divided_word_clock,
    // Receive words
    input wire logic rx_fifo_enable,
    output logic rx_valid,
    output logic [DATA_WIDTH-1:0] rx_word,
    input wire logic rx_ready,
    output logic rx_overflow,
    input wire logic rx_overflow_clear,
    // Transmit words
    input wire logic tx_valid,
    input wire logic [DATA_WIDTH-1:0] tx_word,
    output logic tx_ready,
    // Nibble calibration
    input wire logic [NATIVE_LINES-1:0] native_cal_done,
    input wire logic [COMPONENT_LINES-1:0] component_cal_done,
    output logic calibration_done_flag,
    output logic app_release
);
    import sdc_pkg::*;

    localparam int unsigned DIV = DATA_WIDTH / SDC_DDR_BITS;
    localparam int unsigned CNT_W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CNT_W-1:0] DIV_LAST = CNT_W'(DIV - 1);
    localparam logic [SDC_RELEASE_CNT_W-1:0] RELEASE_LAST =
        SDC_RELEASE_CNT_W'(SDC_RELEASE_CYCLES - 1);

    // Widths must split evenly into bit pairs; refused while elaborating
    if (DATA_WIDTH < SDC_DDR_BITS || DATA_WIDTH % SDC_DDR_BITS != 0) begin : g_bad_width
        $error("DATA_WIDTH must be an even value of at least two");
    end
    if (NATIVE_LINES < 1 || COMPONENT_LINES < 1) begin : g_bad_lines
        $error("each nibble needs at least one delay line of each kind");
    end
    // The release counter must hold the full settling count
    if (SDC_RELEASE_CYCLES >= (1 << SDC_RELEASE_CNT_W)) begin : g_bad_release
        $error("release counter too narrow for the settling count");
    end

    // Word divider: fast clock over width/2 (RQ2); width two ticks every cycle
    logic [CNT_W-1:0] div_cnt;
    wire word_tick = (div_cnt == DIV_LAST); // RQ7
    wire [CNT_W-1:0] next_div_cnt = word_tick ? '0 : div_cnt + CNT_W'(1);
    wire next_tick = (next_div_cnt == DIV_LAST);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            div_cnt <= '0;
            divided_word_clock <= (DIV == 1);
        end else begin
            div_cnt <= next_div_cnt; // RQ2
            divided_word_clock <= next_tick;
        end
    end

    // Deserializer: rise phase bit lands below fall bit, first pair in bit 0
    logic [DATA_WIDTH-1:0] rx_shift;
    wire [DATA_WIDTH-1:0] next_rx_shift;
    if (DIV == 1) begin : g_rx_pair
        assign next_rx_shift = {ser_in_fall, ser_in_rise};
    end else begin : g_rx_shift
        assign next_rx_shift = {ser_in_fall, ser_in_rise, rx_shift[DATA_WIDTH-1:SDC_DDR_BITS]};
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_shift <= '0;
        end else begin
            rx_shift <= next_rx_shift; // RQ1
        end
    end

    // Drain by the fabric in FIFO mode, else by the internal strobe
    wire buf_in_ready;
    wire buf_out_ready = rx_fifo_enable ? rx_ready : word_tick; // RQ4
    wire rx_push = word_tick;
    wire rx_drop = rx_push && !buf_in_ready;

    sdc_word_buffer #(
        .WIDTH(DATA_WIDTH)
    ) u_word_buffer (
        .core_clk(core_clk),
        .reset(reset),
        .in_valid(rx_push),
        .in_data(next_rx_shift),
        .in_ready(buf_in_ready),
        .out_valid(rx_valid),
        .out_data(rx_word),
        .out_ready(buf_out_ready)
    );

    // Sticky loss flag; a new loss wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_overflow <= SDC_FLAG_RESET;
        end else if (rx_drop) begin
            rx_overflow <= 1'b1;
        end else if (rx_overflow_clear) begin
            rx_overflow <= 1'b0;
        end
    end

    // Serializer: word taken only on the divided strobe
    logic [DATA_WIDTH-1:0] tx_shift;
    wire tx_take = word_tick && tx_valid; // RQ5
    wire [DATA_WIDTH-1:0] tx_src = word_tick ? (tx_valid ? tx_word : '0) : tx_shift;
    wire [DATA_WIDTH-1:0] next_tx_shift = tx_src >> SDC_DDR_BITS;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_ready <= (DIV == 1);
            tx_shift <= '0;
            ser_out_rise <= 1'b0;
            ser_out_fall <= 1'b0;
        end else begin
            tx_ready <= next_tick; // RQ5
            tx_shift <= next_tx_shift;
            ser_out_rise <= tx_src[0]; // RQ6
            ser_out_fall <= tx_src[1]; // RQ6
        end
    end

    // Block tristate passes straight through; a registered one belongs in fabric
    assign pad_oe_n = tx_block_tri; // RQ8

    // Nibble ready needs every native and component delay line calibrated
    wire all_cal_done = (&native_cal_done) && (&component_cal_done);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            calibration_done_flag <= SDC_FLAG_RESET;
        end else begin
            calibration_done_flag <= all_cal_done; // RQ11
        end
    end

    // Release sequencer: hold off the application after ready settles
    sdc_release_state_t rel_state;
    sdc_release_state_t next_rel_state;
    logic [SDC_RELEASE_CNT_W-1:0] rel_cnt;
    wire rel_done = (rel_cnt == RELEASE_LAST);

    always_comb begin
        next_rel_state = rel_state;
        unique case (rel_state)
            SDC_CAL_WAIT: begin
                if (calibration_done_flag) begin
                    next_rel_state = SDC_CAL_HOLD;
                end
            end
            SDC_CAL_HOLD: begin
                if (!calibration_done_flag) begin
                    next_rel_state = SDC_CAL_WAIT;
                end else if (rel_done) begin
                    next_rel_state = SDC_CAL_RUN; // RQ12
                end
            end
            SDC_CAL_RUN: begin
                if (!calibration_done_flag) begin
                    next_rel_state = SDC_CAL_WAIT;
                end
            end
            default: begin
                next_rel_state = SDC_CAL_WAIT;
            end
        endcase
    end

    // Counter runs only while holding; a lost ready restarts the wait
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rel_state <= SDC_CAL_WAIT;
            rel_cnt <= '0;
            app_release <= SDC_FLAG_RESET;
        end else begin
            rel_state <= next_rel_state;
            rel_cnt <= (rel_state == SDC_CAL_HOLD) ? rel_cnt + SDC_RELEASE_CNT_W'(1) : '0;
            app_release <= (next_rel_state == SDC_CAL_RUN);
        end
    end

    // Helper counters watched only by the checks below
    logic [CNT_W:0] tick_gap;
    logic [SDC_RELEASE_CNT_W:0] ready_run;
    wire [SDC_DDR_BITS-1:0] tx_head = tx_word[SDC_DDR_BITS-1:0];
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tick_gap <= '0;
            ready_run <= '0;
        end else begin
            tick_gap <= word_tick ? '0 : tick_gap + (CNT_W + 1)'(1);
            if (!calibration_done_flag) begin
                ready_run <= '0;
            end else if (!ready_run[SDC_RELEASE_CNT_W]) begin
                ready_run <= ready_run + (SDC_RELEASE_CNT_W + 1)'(1);
            end
        end
    end

    a_tick_period: assert property (@(posedge core_clk) disable iff (reset) // RQ2
        word_tick |-> tick_gap == (CNT_W + 1)'(DIV - 1))
        else $error("divided strobe period wrong");
    a_strobe_align: assert property (@(posedge core_clk) disable iff (reset) // RQ5
        divided_word_clock == word_tick && tx_ready == word_tick)
        else $error("word strobe out of step with divider");
    a_rx_capture: assert property (@(posedge core_clk) disable iff (reset) // RQ1
        1'b1 |=> rx_shift[DATA_WIDTH-1] == $past(ser_in_fall)
            && rx_shift[DATA_WIDTH-2] == $past(ser_in_rise))
        else $error("serial bits not captured");
    a_rx_no_fifo: assert property (@(posedge core_clk) disable iff (reset) // RQ4
        !rx_fifo_enable && rx_valid && !word_tick |=> rx_valid && $stable(rx_word))
        else $error("word moved between internal strobes");
    a_tx_first_pair: assert property (@(posedge core_clk) disable iff (reset) // RQ6
        tx_take |=> {ser_out_fall, ser_out_rise} == $past(tx_head))
        else $error("first serial pair wrong");
    a_tri_feed: assert property (@(posedge core_clk) disable iff (reset) // RQ8
        pad_oe_n == tx_block_tri)
        else $error("tristate not fed through");
    a_cal_all: assert property (@(posedge core_clk) disable iff (reset) // RQ11
        calibration_done_flag |-> &$past(native_cal_done) && &$past(component_cal_done))
        else $error("ready raised with a line uncalibrated");
    a_release_wait: assert property (@(posedge core_clk) disable iff (reset) // RQ12
        app_release |-> ready_run >= (SDC_RELEASE_CNT_W + 1)'(SDC_RELEASE_CYCLES))
        else $error("application released too early");
    a_overflow_sticky: assert property (@(posedge core_clk) disable iff (reset)
        rx_drop |=> rx_overflow)
        else $error("lost word not flagged");

    // Reverse directions, so a stuck-low flag or a lazy release cannot pass
    a_cal_follow: assert property (@(posedge core_clk) disable iff (reset) // RQ11
        &native_cal_done && &component_cal_done |=> calibration_done_flag)
        else $error("ready not raised with all lines calibrated");
    a_release_drop: assert property (@(posedge core_clk) disable iff (reset) // RQ12
        !calibration_done_flag |=> !app_release)
        else $error("release kept after ready dropped");
    a_release_exact: assert property (@(posedge core_clk) disable iff (reset) // RQ12
        $rose(app_release) |-> ready_run == (SDC_RELEASE_CNT_W + 1)'(SDC_RELEASE_CYCLES + 1))
        else $error("release not at the settling count");
    a_overflow_clear: assert property (@(posedge core_clk) disable iff (reset)
        rx_overflow_clear && !rx_drop |=> !rx_overflow)
        else $error("loss flag not cleared");
    a_tx_idle_zero: assert property (@(posedge core_clk) disable iff (reset) // RQ6
        word_tick && !tx_valid |=> !ser_out_rise && !ser_out_fall)
        else $error("idle take did not send zeros");

    c_rx_word: cover property (@(posedge core_clk) disable iff (reset) rx_valid && rx_ready);
    c_tx_word: cover property (@(posedge core_clk) disable iff (reset) tx_take);
    c_release: cover property (@(posedge core_clk) disable iff (reset) $rose(app_release));
    c_overflow: cover property (@(posedge core_clk) disable iff (reset) rx_drop);
endmodule : sdc_serdes
`default_nettype wire

// *** verif/sdc_fabric_model.sv ***
// Fabric-side model that feeds transmit words and drains receive words
`timescale 1ns/10ps
`default_nettype none
module sdc_fabric_model #(
    parameter int unsigned DW = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic stall,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [DW-1:0] tx_word,
    input wire logic rx_valid,
    input wire logic [DW-1:0] rx_word,
    output logic rx_ready
);
    logic [DW-1:0] tx_q[$];
    logic [DW-1:0] rx_q[$];

    // A word leaves only when the divided strobe takes it
    always @(posedge core_clk) begin
        if (!reset && tx_valid && tx_ready && tx_q.size() > 0) begin
            void'(tx_q.pop_front());
        end
        if (!reset && rx_valid && rx_ready) begin
            rx_q.push_back(rx_word);
        end
    end

    // Idle data toggles so a stale word can never pass for a fresh one
    always @(negedge core_clk) begin
        if (reset) begin
            tx_valid <= 1'h0;
            tx_word <= '0;
            rx_ready <= 1'h0;
        end else begin
            tx_valid <= (tx_q.size() > 0);
            tx_word <= (tx_q.size() > 0) ? tx_q[0] : ~tx_word;
            rx_ready <= !stall;
        end
    end
endmodule : sdc_fabric_model
`default_nettype wire

// *** verif/sdc_serdes_test.sv ***
// Self-checking bench for the serdes clocking block with a fabric model
`timescale 1ns/10ps
`default_nettype none
module sdc_serdes_test;
    import sdc_pkg::*;
    localparam int DW = SDC_DATA_WIDTH;
    localparam int DIV = DW / 2;
    localparam int NL = SDC_NATIVE_LINES;
    localparam int CL = SDC_COMPONENT_LINES;
    logic core_clk = 1'h0;
    logic reset = 1'h1;
    logic ser_in_rise = 1'h0;
    logic ser_in_fall = 1'h0;
    logic tx_block_tri = 1'h0;
    logic rx_fifo_enable = 1'h0;
    logic rx_overflow_clear = 1'h0;
    logic stall = 1'h0;
    logic ser_out_rise, ser_out_fall, pad_oe_n, divided_word_clock;
    logic rx_valid, rx_ready, rx_overflow, tx_valid, tx_ready, cal_flag, app_release;
    logic [DW-1:0] rx_word, tx_word;
    logic [NL-1:0] native_cal_done = '0;
    logic [CL-1:0] component_cal_done = '0;
    // Reference rate setting in MHz, any plain value serves
    localparam int REF_RATE = 300;
    int line_rate [NL+CL];
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #5 core_clk = ~core_clk;

    sdc_serdes sdc_serdes_i (.core_clk(core_clk), .reset(reset),
        .ser_in_rise(ser_in_rise), .ser_in_fall(ser_in_fall),
        .ser_out_rise(ser_out_rise), .ser_out_fall(ser_out_fall),
        .tx_block_tri(tx_block_tri), .pad_oe_n(pad_oe_n),
        .divided_word_clock(divided_word_clock), .rx_fifo_enable(rx_fifo_enable),
        .rx_valid(rx_valid), .rx_word(rx_word), .rx_ready(rx_ready),
        .rx_overflow(rx_overflow), .rx_overflow_clear(rx_overflow_clear),
        .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready),
        .native_cal_done(native_cal_done), .component_cal_done(component_cal_done),
        .calibration_done_flag(cal_flag), .app_release(app_release));

    sdc_fabric_model #(.DW(DW)) sdc_fabric_model_i (.core_clk(core_clk), .reset(reset),
        .stall(stall), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_word(tx_word),
        .rx_valid(rx_valid), .rx_word(rx_word), .rx_ready(rx_ready));

    task automatic check(input string what, input logic [DW-1:0] seen,
                         input logic [DW-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // Cut a hang short; the whole run needs well under this
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            conclude();
        end
    end

    // Stop at the falling edge inside the cycle where the strobe is high
    task automatic sync_strobe;
        int n;
        n = 0;
        @(negedge core_clk);
        while (divided_word_clock !== 1'h1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        check("strobe found", divided_word_clock, 1'h1);
    endtask : sync_strobe

    // One bit pair per cycle, earlier bit on the rising phase
    task automatic send_word(input logic [DW-1:0] w, input logic chk,
                             input logic [DW-1:0] prev);
        for (int k = 0; k < DIV; k++) begin
            @(negedge core_clk);
            if (chk && k == 0) begin
                check("rx valid", rx_valid, 1'h1);
                check("rx word", rx_word, prev);
            end
            ser_in_rise = w[2*k];
            ser_in_fall = w[2*k+1];
        end
    endtask : send_word

    task automatic check_tx(input logic [DW-1:0] w);
        for (int k = 0; k < DIV; k++) begin
            @(negedge core_clk);
            check("tx pair", {ser_out_fall, ser_out_rise}, w[2*k+:2]);
        end
    endtask : check_tx

    task automatic test_reset_values;
        check("reset rx valid", rx_valid, 1'h0);
        check("reset strobe", divided_word_clock, 1'h0);
        check("reset overflow", rx_overflow, 1'h0);
        check("reset release", app_release, 1'h0);
    endtask : test_reset_values

    task automatic test_divider;
        sync_strobe();
        for (int i = 1; i <= DIV; i++) begin
            @(negedge core_clk);
            check("word strobe", divided_word_clock, i == DIV);
            check("tx take", tx_ready, i == DIV);
        end
    endtask : test_divider

    // Without the FIFO words drain on the strobe even while fabric stalls
    task automatic test_rx_direct;
        stall <= 1'h1;
        sync_strobe();
        send_word(8'h5c, 1'h0, '0);
        send_word(8'ha3, 1'h1, 8'h5c);
        send_word(8'h0f, 1'h1, 8'ha3);
        send_word(8'hf0, 1'h1, 8'h0f);
    endtask : test_rx_direct

    // A stall fills the two entries, later words are lost, oldest kept
    task automatic test_rx_fifo;
        int n0;
        rx_fifo_enable = 1'h1;
        stall <= 1'h0;
        repeat (3 * DIV) @(negedge core_clk);
        sync_strobe();
        send_word(8'h96, 1'h0, '0);
        stall <= 1'h1;
        send_word(8'h3c, 1'h0, '0);
        send_word(8'he1, 1'h0, '0);
        send_word(8'h7e, 1'h0, '0);
        @(negedge core_clk);
        check("overflow", rx_overflow, 1'h1);
        n0 = sdc_fabric_model_i.rx_q.size();
        stall <= 1'h0;
        repeat (DIV) @(negedge core_clk);
        check("first kept", sdc_fabric_model_i.rx_q[n0], 8'h96);
        check("second kept", sdc_fabric_model_i.rx_q[n0+1], 8'h3c);
        rx_overflow_clear = 1'h1;
        @(negedge core_clk);
        rx_overflow_clear = 1'h0;
        @(negedge core_clk);
        check("overflow cleared", rx_overflow, 1'h0);
    endtask : test_rx_fifo

    // Two words back to back, then an idle take that sends zeros
    task automatic test_tx;
        int n;
        n = 0;
        sdc_fabric_model_i.tx_q.push_back(8'hb4);
        sdc_fabric_model_i.tx_q.push_back(8'h2d);
        @(negedge core_clk);
        while (!(tx_ready === 1'h1 && tx_valid === 1'h1) && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        check_tx(8'hb4);
        check("seamless take", tx_ready, 1'h1);
        check_tx(8'h2d);
        check_tx('0);
    endtask : test_tx

    // A registered path would not follow before the next rising edge
    task automatic test_tristate;
        for (int v = 0; v < 2; v++) begin
            @(negedge core_clk);
            tx_block_tri = v[0];
            #1;
            check("pad enable", pad_oe_n, v[0]);
        end
    endtask : test_tristate

    // One line short at a time, then all lines calibrated
    task automatic test_cal;
        logic [NL+CL-1:0] lines;
        for (int j = 0; j < NL + CL; j++) begin
            line_rate[j] = REF_RATE;
        end
        for (int i = 0; i <= NL + CL; i++) begin
            // Delay-line status only moves with the divided word strobe
            sync_strobe();
            for (int j = 0; j < NL + CL; j++) begin
                lines[j] = (j != i) && (line_rate[j] == REF_RATE);
            end
            {component_cal_done, native_cal_done} = lines;
            if (i < NL + CL) begin
                repeat (2) @(negedge core_clk);
                check("partial ready", cal_flag, 1'h0);
            end
        end
        @(negedge core_clk);
        check("all ready", cal_flag, 1'h1);
        repeat (SDC_RELEASE_CYCLES) @(negedge core_clk);
        check("early release", app_release, 1'h0);
        @(negedge core_clk);
        check("release", app_release, 1'h1);
        native_cal_done[0] = 1'h0;
        repeat (2) @(negedge core_clk);
        check("ready drop", cal_flag, 1'h0);
        check("release drop", app_release, 1'h0);
    endtask : test_cal

    initial begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        test_reset_values();
        reset = 1'h0;
        test_divider();
        test_rx_direct();
        test_rx_fifo();
        test_tx();
        test_tristate();
        test_cal();
        conclude();
    end
endmodule : sdc_serdes_test
`default_nettype wire
